// ---- mmd_decoder.sv ----
// Memory map decoder: placement latch, region select, fetch timing, call targets.
// Assumes a core issuing one registered request per cycle; answers next cycle.
`timescale 1ns/1ps
module mmd_decoder (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Placement instruction
    input  wire logic        PLACE_VALID,
    input  wire logic [3:0]  PLACE_CODE,
    // Mode controls
    input  wire logic        EXP_MODE,
    input  wire logic        FAST_FETCH_EN,
    // Access request
    input  wire logic        REQ,
    input  wire logic        REQ_FETCH,
    input  wire logic [19:0] REQ_ADDR,
    // Call targets
    input  wire logic        TCALL_REQ,
    input  wire logic [4:0]  TCALL_IDX,
    input  wire logic        FCALL_REQ,
    input  wire logic [10:0] FCALL_OFS,
    input  wire logic        VEC_REQ,
    input  wire logic [4:0]  VEC_IDX,
    // Region selects
    output logic             SEL_ROM,
    output logic             SEL_DATA,
    output logic             SEL_SFR,
    output logic             SEL_EXT,
    output logic             ACC_BLOCKED,
    output logic             IN_BASE,
    output logic [1:0]       WAIT_CNT,
    output logic             FAST_FETCH,
    output logic             FETCH_FAULT,
    // Placement state
    output logic             PLACED,
    output logic             PLACE_HIGH_Q,
    // Table address for calls and vectors
    output logic             TBL_VALID,
    output logic [19:0]      TBL_ADDR
);
    logic        placed_r;
    logic        high_r;
    logic        fast_r;
    logic [19:0] d_lo;
    logic [19:0] d_off;
    logic        in_data;
    logic        in_sfr;
    logic        in_fram;
    logic        in_rom;

    // Address moved down to the low placement; both placements share one compare
    function automatic logic [19:0] rel(input logic [19:0] a, input logic hi);
        rel = hi ? (a - mmd_pkg::DATA_TOP_OFS) : a;
    endfunction

    // Inclusive address range test shared by the range checks below
    function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // One-time placement latch
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            placed_r <= 1'b0;
            high_r   <= 1'b0;
        end else if (PLACE_VALID && !placed_r) begin
            placed_r <= 1'b1;
            high_r   <= (PLACE_CODE == mmd_pkg::PLACE_HIGH);
        end
    end

    // Fetch speed control; reset puts ROM at external-equivalent speed
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            fast_r <= 1'b0;
        else
            fast_r <= FAST_FETCH_EN;
    end

    always_comb begin
        d_off   = rel(REQ_ADDR, high_r);
        d_lo    = high_r ? (mmd_pkg::DATA_LO_BASE + mmd_pkg::DATA_TOP_OFS) : mmd_pkg::DATA_LO_BASE;
        in_data = (REQ_ADDR >= d_lo) && (d_off <= mmd_pkg::BASE_AREA_END)
                  && (!high_r || REQ_ADDR >= mmd_pkg::DATA_TOP_OFS);
        in_sfr  = in_data && (d_off >= mmd_pkg::SFR_LO_BASE);
        in_fram = in_data && (d_off >= mmd_pkg::FRAM_LO_BASE);
        in_rom  = (REQ_ADDR <= mmd_pkg::ROM_END) && !in_data;
    end

    // Region select, registered; data area has priority
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SEL_ROM     <= 1'b0;
            SEL_DATA    <= 1'b0;
            SEL_SFR     <= 1'b0;
            SEL_EXT     <= 1'b0;
            ACC_BLOCKED <= 1'b0;
            IN_BASE     <= 1'b0;
            FETCH_FAULT <= 1'b0;
        end else begin
            SEL_ROM     <= REQ && in_rom;
            SEL_DATA    <= REQ && in_data && !in_sfr;
            SEL_SFR     <= REQ && in_sfr;
            SEL_EXT     <= REQ && !in_rom && !in_data && EXP_MODE;
            ACC_BLOCKED <= REQ && !in_rom && !in_data && !EXP_MODE;
            IN_BASE     <= REQ && (REQ_ADDR <= mmd_pkg::BASE_AREA_END);
            // Flags a core fetch into fast RAM or registers; core must avoid it
            FETCH_FAULT <= REQ && REQ_FETCH && in_fram;
        end
    end

    // Waits and fetch width for ROM fetches
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WAIT_CNT   <= mmd_pkg::SLOW_WAITS;
            FAST_FETCH <= 1'b0;
        end else begin
            WAIT_CNT   <= (REQ && REQ_FETCH && in_rom && fast_r) ? mmd_pkg::FAST_WAITS
                                                                 : mmd_pkg::SLOW_WAITS;
            FAST_FETCH <= REQ && REQ_FETCH && in_rom && fast_r;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PLACED       <= 1'b0;
            PLACE_HIGH_Q <= 1'b0;
        end else begin
            PLACED       <= placed_r;
            PLACE_HIGH_Q <= high_r;
        end
    end

    // Table addresses: 16-bit entries, so targets always stay in the base area
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            TBL_VALID <= 1'b0;
            TBL_ADDR  <= 20'h00000;
        end else begin
            TBL_VALID <= VEC_REQ || TCALL_REQ || FCALL_REQ;
            if (VEC_REQ)
                TBL_ADDR <= {14'h0000, VEC_IDX, 1'b0};
            else if (TCALL_REQ)
                TBL_ADDR <= mmd_pkg::TCALL_BASE | {14'h0000, TCALL_IDX, 1'b0};
            else if (FCALL_REQ)
                TBL_ADDR <= mmd_pkg::FCALL_BASE | {9'h000, FCALL_OFS};
        end
    end

    a_place_once: assert property (@(posedge CLK) disable iff (RST)
        $past(placed_r) |-> $stable(high_r)) else $error("placement changed");
    a_data_wins: assert property (@(posedge CLK) disable iff (RST)
        !(SEL_ROM && (SEL_DATA || SEL_SFR))) else $error("rom selected in data area");
    a_ext_mode: assert property (@(posedge CLK) disable iff (RST)
        SEL_EXT |-> $past(EXP_MODE)) else $error("external without expansion");
    a_fast_nowait: assert property (@(posedge CLK) disable iff (RST)
        FAST_FETCH |-> WAIT_CNT == mmd_pkg::FAST_WAITS) else $error("waits on fast fetch");
    a_sfr_range: assert property (@(posedge CLK) disable iff (RST)
        (REQ && !high_r && in_rng(REQ_ADDR, mmd_pkg::SFR_LO_BASE, mmd_pkg::BASE_AREA_END)) |=> SEL_SFR)
        else $error("sfr missed");
    a_rom_low: assert property (@(posedge CLK) disable iff (RST)
        (REQ && !high_r && in_rng(REQ_ADDR, mmd_pkg::DATA_LO_BASE, mmd_pkg::BASE_AREA_END)) |=> !SEL_ROM)
        else $error("rom in data area");
    a_rom_high: assert property (@(posedge CLK) disable iff (RST)
        (REQ && high_r && REQ_ADDR <= mmd_pkg::ROM_END) |=> SEL_ROM) else $error("rom missed");
    a_fcall_rng: assert property (@(posedge CLK) disable iff (RST)
        (FCALL_REQ && !VEC_REQ && !TCALL_REQ) |=> in_rng(TBL_ADDR, mmd_pkg::FCALL_BASE, mmd_pkg::FCALL_END))
        else $error("fixed call range");
    a_tcall_rng: assert property (@(posedge CLK) disable iff (RST)
        (TCALL_REQ && !VEC_REQ) |=> in_rng(TBL_ADDR, mmd_pkg::TCALL_BASE, 20'h0007F))
        else $error("table call range");

    // Placement steps: taken on one edge, latched, shown one edge later
    sequence s_place_take;
        PLACE_VALID && !placed_r;
    endsequence
    sequence s_place_show;
        placed_r ##1 PLACED;
    endsequence
    sequence s_high_take;
        s_place_take ##0 (PLACE_CODE == mmd_pkg::PLACE_HIGH);
    endsequence
    sequence s_low_take;
        s_place_take ##0 (PLACE_CODE != mmd_pkg::PLACE_HIGH);
    endsequence
    a_place_seen: assert property (@(posedge CLK) disable iff (RST)
        s_place_take |=> s_place_show) else $error("placement not latched");
    a_place_high: assert property (@(posedge CLK) disable iff (RST)
        s_high_take |=> high_r ##1 PLACE_HIGH_Q) else $error("high placement lost");
    a_place_low: assert property (@(posedge CLK) disable iff (RST)
        s_low_take |=> !high_r ##1 !PLACE_HIGH_Q) else $error("low placement lost");

    // Region checks across the whole map
    a_blocked_mode: assert property (@(posedge CLK) disable iff (RST)
        ACC_BLOCKED |-> !$past(EXP_MODE)) else $error("blocked in expansion mode");
    a_ext_region: assert property (@(posedge CLK) disable iff (RST)
        (REQ && EXP_MODE && REQ_ADDR > mmd_pkg::ROM_END
         && !(high_r && REQ_ADDR >= mmd_pkg::DATA_LO_BASE + mmd_pkg::DATA_TOP_OFS)) |=> SEL_EXT)
        else $error("unclaimed address not external");
    a_data_high: assert property (@(posedge CLK) disable iff (RST)
        (REQ && high_r && REQ_ADDR >= mmd_pkg::DATA_LO_BASE + mmd_pkg::DATA_TOP_OFS) |=> SEL_DATA || SEL_SFR)
        else $error("high data area missed");
    a_base_internal: assert property (@(posedge CLK) disable iff (RST)
        IN_BASE |-> !SEL_EXT && !ACC_BLOCKED) else $error("base area left internal memory");
    a_in_base: assert property (@(posedge CLK) disable iff (RST)
        (REQ && REQ_ADDR <= mmd_pkg::BASE_AREA_END) |=> IN_BASE) else $error("base area missed");
    a_fault_low: assert property (@(posedge CLK) disable iff (RST)
        (REQ && REQ_FETCH && !high_r && in_rng(REQ_ADDR, mmd_pkg::FRAM_LO_BASE, mmd_pkg::BASE_AREA_END))
        |=> FETCH_FAULT) else $error("fetch fault missed");
    a_fault_high: assert property (@(posedge CLK) disable iff (RST)
        (REQ && REQ_FETCH && high_r && in_rng(REQ_ADDR, mmd_pkg::FRAM_LO_BASE + mmd_pkg::DATA_TOP_OFS,
         mmd_pkg::BASE_AREA_END + mmd_pkg::DATA_TOP_OFS)) |=> FETCH_FAULT) else $error("high fetch fault missed");

    // Fetch timing and table targets
    a_slow_waits: assert property (@(posedge CLK) disable iff (RST)
        (REQ && REQ_FETCH && in_rom && !fast_r) |=> WAIT_CNT == mmd_pkg::SLOW_WAITS) else $error("slow waits missed");
    a_vec_range: assert property (@(posedge CLK) disable iff (RST)
        VEC_REQ |=> TBL_ADDR <= mmd_pkg::VECT_END && !TBL_ADDR[0])
        else $error("vector range");
    a_tbl_idle: assert property (@(posedge CLK) disable iff (RST)
        !(VEC_REQ || TCALL_REQ || FCALL_REQ) |=> !TBL_VALID) else $error("table strobe without request");
    a_reset_slow: assert property (@(posedge CLK) disable iff (RST)
        $fell(RST) |-> !FAST_FETCH && !fast_r) else $error("fast fetch after reset");
endmodule

// ---- mmd_pkg.sv ----
// Constants shared by the memory map decoder.
// Assumes 20-bit byte addresses from the CPU core and one 40 MHz clock.
// Notes on behaviour
// - Decode a one-megabyte linear space with 20-bit addresses.
// - Internal RAM plus register area decode as one block ending at final address.
// - Data area ends at 0FFFFH under setting 0, at top of megabyte under 0FH.
// - Largest variant data area spans 0D600H to 0FFFFH under setting 0.
// - Under setting 0FH every data area address moves up by 0F0000H.
// - Special function registers decode at 0FF00H to 0FFFFH, top 256 bytes.
// - Placement is issued once after reset; later attempts are ignored.
// - Data area wins over any overlapping region, which is blocked.
// - ROM at 00000H-0D5FFH and 10000H-3FFFFH, or 00000H-3FFFFH under 0FH.
// - External accesses happen only in external expansion mode.
// - Fast fetch enabled gives two bytes per two clocks from ROM.
// - Waits on ROM fetches only at external-equivalent timing, never when fast.
// - Reset selects external-equivalent fetch timing, fast fetch off.
// - Addresses 0 to FFFFH form the base area.
// - 00000H to 0003FH is the vector table.
// - Vector entries are 16-bit, so vectored branches stay in base area.
// - Table call reads a 16-bit entry at 00040H-0007FH, up to 32 entries.
// - Fixed-area call reaches targets 00800H to 00FFFH.
// - Unused vector slots act as ordinary memory.
package mmd_pkg;
    localparam int          ADDR_W         = 20;
    localparam logic [19:0] DATA_LO_BASE   = 20'h0D600;
    localparam logic [19:0] DATA_TOP_OFS   = 20'hF0000;
    localparam logic [19:0] SFR_LO_BASE    = 20'h0FF00;
    localparam logic [19:0] FRAM_LO_BASE   = 20'h0FD00;
    localparam logic [19:0] BASE_AREA_END  = 20'h0FFFF;
    localparam logic [19:0] ROM_END        = 20'h3FFFF;
    localparam logic [19:0] VECT_END       = 20'h0003F;
    localparam logic [19:0] TCALL_BASE     = 20'h00040;
    localparam logic [19:0] FCALL_BASE     = 20'h00800;
    localparam logic [19:0] FCALL_END      = 20'h00FFF;
    localparam logic [3:0]  PLACE_LOW      = 4'h0;
    localparam logic [3:0]  PLACE_HIGH     = 4'hF;
    localparam logic [1:0]  FAST_WAITS     = 2'h0;
    localparam logic [1:0]  SLOW_WAITS     = 2'h2;
    localparam logic [1:0]  FAST_FETCH_CLK = 2'h2;
    typedef enum logic [1:0] {MMD_SEL_NONE, MMD_SEL_ROM, MMD_SEL_DATA, MMD_SEL_EXT} mmd_sel_e;
endpackage

// ---- mmd_core_model.sv ----
// Core model: issues one access at a time to the decoder.
// Assumes the caller sits at a falling edge of clk.
`timescale 1ns/1ps
module mmd_core_model (
    // Clock
    input  wire logic        clk,
    // Access request
    output logic             req,
    output logic             req_fetch,
    output logic [19:0]      req_addr
);
    initial begin
        req       = 1'b0;
        req_fetch = 1'b0;
        req_addr  = 20'h00000;
    end
    // Held over one taking edge; idle address scrambled so stale values never match
    task automatic issue(input logic [19:0] a, input logic f, input logic bad, input logic hi);
        logic [19:0] r;
        r = hi ? a - 20'hF0000 : a;
        @(negedge clk);
        req       <= 1'b1;
        // Addresses only, no data comes back, so no uninitialised RAM value is consumed
        req_addr  <= a;
        req_fetch <= f && (bad || !(r >= 20'h0FD00 && r <= 20'h0FFFF));
        @(negedge clk);
        req       <= 1'b0;
        req_addr  <= ~a;
        req_fetch <= 1'b0;
    endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the memory map decoder.
// Assumes answers by the falling edge after the taking edge, placement within three.
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, pv = 1'b0, xm = 1'b0, ffe = 1'b0;
    logic        vr = 1'b0, tr = 1'b0, fr = 1'b0, hi, f, bad;
    logic [3:0]  pc = 4'h0;
    logic [4:0]  vi = 5'h00, ti = 5'h00;
    logic [10:0] fo = 11'h000;
    logic [19:0] a, ta, ea;
    wire  [6:0]  sel;
    logic [6:0]  e;
    logic [1:0]  wc;
    logic        req, rf, ff, placed, phq, tv;
    logic [19:0] ra;
    int          n_errors = 0, samples_checked = 0;
    logic [19:0] cor [15] = '{20'h00000, 20'h0D5FF, 20'h0D600, 20'h0FCFF, 20'h0FD00, 20'h0FEFF, 20'h0FF00,
                              20'h0FFFF, 20'h10000, 20'h3FFFF, 20'h40000, 20'hFD5FF, 20'hFD600, 20'hFFF00, 20'hFFFFF};
    logic [3:0]  codes [3] = '{4'h0, 4'hF, 4'h3};
    always #12.5 clk = ~clk;
    mmd_core_model core (.clk(clk), .req(req), .req_fetch(rf), .req_addr(ra));
    mmd_decoder dut (.CLK(clk), .RST(rst), .PLACE_VALID(pv), .PLACE_CODE(pc), .EXP_MODE(xm),
        .FAST_FETCH_EN(ffe), .REQ(req), .REQ_FETCH(rf), .REQ_ADDR(ra), .TCALL_REQ(tr), .TCALL_IDX(ti),
        .FCALL_REQ(fr), .FCALL_OFS(fo), .VEC_REQ(vr), .VEC_IDX(vi), .SEL_ROM(sel[6]), .SEL_DATA(sel[5]),
        .SEL_SFR(sel[4]), .SEL_EXT(sel[3]), .ACC_BLOCKED(sel[2]), .IN_BASE(sel[1]), .FETCH_FAULT(sel[0]),
        .WAIT_CNT(wc), .FAST_FETCH(ff), .PLACED(placed), .PLACE_HIGH_Q(phq), .TBL_VALID(tv), .TBL_ADDR(ta));
    // Region select vector in port order, worked out from the map
    function automatic logic [6:0] exp_sel(logic [19:0] ad, logic fe, logic h, logic x);
        logic [19:0] r;
        logic        d, s, rom;
        r   = h ? ad - 20'hF0000 : ad;
        d   = h ? ad >= 20'hFD600 : (ad >= 20'h0D600 && ad <= 20'h0FFFF);
        s   = d && r >= 20'h0FF00;
        rom = !d && ad <= 20'h3FFFF;
        return {rom, d && !s, s, !d && !rom && x, !d && !rom && !x, ad <= 20'h0FFFF, fe && d && r >= 20'h0FD00};
    endfunction
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] ex);
        samples_checked++;
        if (seen !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic place(input logic [3:0] c);
        @(negedge clk);
        pv = 1'b1;
        pc = c;
        @(negedge clk);
        pv = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        void'($urandom(28475));
        foreach (codes[i]) begin
            rst = 1'b1;
            ffe = (i != 0);
            repeat (3) @(negedge clk);
            chk("reset", {wc, ff, placed, phq, tv, sel}, {2'h2, 11'h000});
            rst = 1'b0;
            hi  = (codes[i] == 4'hF);
            place(codes[i]);
            chk("placed", {placed, phq}, {1'b1, hi});
            place(hi ? 4'h0 : 4'hF);
            chk("locked", {placed, phq}, {1'b1, hi});
            for (int j = 0; j < 60; j++) begin
                a   = (j < 30) ? cor[j % 15] : 20'($urandom);
                xm  = j[0];
                // Corners always fetch: first pass strays into fast RAM, second keeps out
                f   = (j < 30) | 1'($urandom);
                bad = (j < 30) ? (j < 15) : 1'($urandom);
                core.issue(a, f, bad, hi);
                e = exp_sel(a, f && bad, hi, xm);
                chk("select", sel, e);
                if (e[6] && f) chk("fetch", {ff, wc}, {ffe, ffe ? 2'h0 : 2'h2});
            end
            for (int k = 0; k < 12; k++) begin
                @(negedge clk);
                {vr, tr, fr} = 3'($urandom);
                {vi, ti, fo} = 21'($urandom);
                ea = vr ? {14'h0000, vi, 1'b0} : tr ? 20'h00040 + {14'h0000, ti, 1'b0} : 20'h00800 + {9'h000, fo};
                @(negedge clk);
                chk("tvalid", tv, vr | tr | fr);
                if (vr | tr | fr) chk("taddr", ta, ea);
                {vr, tr, fr} = 3'h0;
            end
        end
        stop_test();
    end
endmodule
